// *** hdl/esc_pkg.sv ***
`default_nettype none
// shared constants for the exception syndrome capture block
// bit positions are little-endian vector indices: index = 31 - documented bit number
package esc_pkg;

	// register width and value after reset
	localparam int          ESC_WIDTH = 32;
	localparam logic [31:0] ESC_RESET = 32'h0000_0000;

	// software-writable bits; reserved bits 9 and 16..26 stay zero
	localparam logic [31:0] ESC_WRITE_MASK = 32'hFFBF_001F;

	// bits 0..7, filled by the earlier syndrome logic
	localparam int ESC_POS_LOW_HI   = 31;
	localparam int ESC_POS_LOW_LO   = 24;
	// bit 8, store-type access
	localparam int ESC_POS_STORE    = 23;
	// bits 10..11, locking-fault source
	localparam int ESC_POS_LOCK_HI  = 21;
	localparam int ESC_POS_LOCK_LO  = 20;
	// bit 12, auxiliary processor instruction
	localparam int ESC_POS_AUX      = 19;
	// bit 13, unimplemented operation
	localparam int ESC_POS_UNIMPL   = 18;
	// bit 14, byte ordering
	localparam int ESC_POS_BYTE     = 17;
	// bit 15, imprecise report
	localparam int ESC_POS_IMPREC   = 16;
	// bit 27, floating-point condition update
	localparam int ESC_POS_CRUPD    = 4;
	// bit 28, floating-point compare
	localparam int ESC_POS_CMP      = 3;
	// bits 29..31, condition field index
	localparam int ESC_POS_FIELD_HI = 2;
	localparam int ESC_POS_FIELD_LO = 0;

	// locking-fault source codes
	localparam logic [1:0] ESC_LOCK_NONE  = 2'h0;
	localparam logic [1:0] ESC_LOCK_FLUSH = 2'h1;
	localparam logic [1:0] ESC_LOCK_INVAL = 2'h2;
	localparam logic [1:0] ESC_LOCK_RSVD  = 2'h3;

	// condition field index when not loaded
	localparam logic [2:0] ESC_FIELD_NONE = 3'h0;

	// whole state of the capture block
	typedef struct packed {
		logic [31:0] syndrome;
	} esc_state_t;

endpackage
`default_nettype wire

// *** hdl/esc_syndrome_capture.sv ***
`default_nettype none
// Function
// - bit 8 marks store or cache-op cause
// - bits 10:11 give locking-fault source code
// - bit 12 marks auxiliary processor instruction
// - bit 13 marks unimplemented-operation program interrupt
// - bit 14 marks byte ordering exception
// - bit 15: 0 precise, 1 imprecise
// - imprecise only for delayed fp-enabled interrupt
// - bit 27 marks fp condition-updating instruction
// - bit 28 marks fp compare instruction
// - bits 29:31 hold target condition field
// - fp qualifiers only for precise fp-enabled
// - capture sets cause bits, clears others
// - software move reads and replaces register
module esc_syndrome_capture
	import esc_pkg::*;
(
	input  wire logic        clk,              // core clock
	input  wire logic        rst,              // async reset, active high
	input  wire logic        ce,               // clock enable, freezes state when low
	input  wire logic        excTake,          // pulse: interrupt that uses the syndrome
	input  wire logic [7:0]  excLowSyndrome,   // bits 0..7 from earlier syndrome logic
	input  wire logic        excStore,         // store-type access or cache op
	input  wire logic [1:0]  excLockSrc,       // locking-fault source code
	input  wire logic        excAux,           // auxiliary processor instruction
	input  wire logic        excProgram,       // interrupt is a program interrupt
	input  wire logic        excUnimpl,        // unimplemented operation
	input  wire logic        excByteOrder,     // byte ordering exception
	input  wire logic        excFpEnabled,     // fp-enabled program interrupt
	input  wire logic        excDelayed,       // raised by a mode write, not the fp op
	input  wire logic        fpExcModeLow,     // fp exception mode, low bit
	input  wire logic        fpExcModeHigh,    // fp exception mode, high bit
	input  wire logic        fpEnabledSummary, // fp unit enabled-exception summary
	input  wire logic        excFpCrUpdate,    // fp op updates a condition field
	input  wire logic        excFpCompare,     // fp compare-type op
	input  wire logic [2:0]  excCrField,       // condition field the op targets
	input  wire logic        sprWrite,         // pulse: software move into register
	input  wire logic [31:0] sprWriteData,     // data of the software move
	output logic      [31:0] syndrome          // register contents, read by software
);

	// registered state and its next value
	esc_state_t state;
	esc_state_t next_state;

	// decoded causes
	logic       impFlag;    // imprecise report for this capture
	logic       qualOk;     // fp qualifiers are meaningful
	logic       crUpd;      // condition-update qualifier
	logic [1:0] lockCode;   // filtered lock source
	logic [31:0] capture;   // full value built on capture

	// lock code filter: the reserved code never lands in the register on a capture
	// a stray 11 from the storage logic would otherwise read back as a
	// cause that software has no handler for
	function automatic logic [1:0] lockFilter(input logic [1:0] code);
		if (code == ESC_LOCK_FLUSH || code == ESC_LOCK_INVAL)
		begin
			return code;
		end
		return ESC_LOCK_NONE;
	endfunction

	// imprecise only for an fp-enabled interrupt caused by a mode raise
	// while the fp unit already shows its summary
	always_comb
	begin
		impFlag = excFpEnabled && excDelayed && fpEnabledSummary
			&& (fpExcModeLow || fpExcModeHigh);
		// qualifiers only for a precise fp-enabled interrupt
		qualOk  = excFpEnabled && !impFlag;
		crUpd   = qualOk && excFpCrUpdate;
		lockCode = lockFilter(excLockSrc);
	end

	// build the captured value: every bit not named by the cause is zero
	// the write mask is applied on capture too, so reserved bits stay zero
	always_comb
	begin
		capture = '0;
		capture[ESC_POS_LOW_HI:ESC_POS_LOW_LO] = excLowSyndrome;
		// store-type access
		capture[ESC_POS_STORE] = excStore;
		// locking fault source
		capture[ESC_POS_LOCK_HI:ESC_POS_LOCK_LO] = lockCode;
		// auxiliary processor op
		capture[ESC_POS_AUX] = excAux;
		// unimplemented op, program interrupts only
		capture[ESC_POS_UNIMPL] = excProgram && excUnimpl;
		// byte ordering
		capture[ESC_POS_BYTE] = excByteOrder;
		// precise or imprecise report
		capture[ESC_POS_IMPREC] = impFlag;
		// condition-update qualifier
		capture[ESC_POS_CRUPD] = crUpd;
		// compare qualifier
		capture[ESC_POS_CMP] = qualOk && excFpCompare;
		// field index only loaded when condition-update is set
		if (crUpd)
		begin
			capture[ESC_POS_FIELD_HI:ESC_POS_FIELD_LO] = excCrField;
		end
		else
		begin
			capture[ESC_POS_FIELD_HI:ESC_POS_FIELD_LO] = ESC_FIELD_NONE;
		end
	end

	// next state: capture beats a software write in the same cycle
	// a handler that rewrites the register just as a new interrupt is
	// taken would otherwise wipe the cause of that interrupt; the write
	// is lost instead, and software sees the newer syndrome
	always_comb
	begin
		next_state = state;
		if (!ce)
		begin
			// frozen
			next_state = state;
		end
		else if (excTake)
		begin
			// hardware event wins, so the cause is never lost
			next_state.syndrome = capture & ESC_WRITE_MASK;
		end
		else if (sprWrite)
		begin
			// software replaces contents, reserved bits dropped
			next_state.syndrome = sprWriteData & ESC_WRITE_MASK;
		end
		else
		begin
			// other interrupt types leave it alone
			next_state = state;
		end
	end

	// state register; reset clears the whole word without a clock
	// only constants load on the reset branch, so the async path stays clean
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state.syndrome <= ESC_RESET;
		end
		else
		begin
			state <= next_state;
		end
	end

	// software reads the register directly
	assign syndrome = state.syndrome;

	// checks on the register; every property samples on the rising clock
	// and is switched off while reset is high, so the async clear is
	// judged by the value it leaves, not by its edge
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// a capture cycle
	sequence takeSeq;
		ce && excTake;
	endsequence

	// a write with no capture beside it
	sequence writeSeq;
		ce && sprWrite && !excTake;
	endsequence

	// a capture followed by the updated register
	sequence takenSeq;
		takeSeq ##1 1'h1;
	endsequence

	// a capture and a software write in one cycle
	sequence bothSeq;
		ce && excTake && sprWrite;
	endsequence

	// a capture that is not a floating-point-enabled interrupt
	sequence nonFpSeq;
		ce && excTake && !excFpEnabled;
	endsequence

	// store-type cause lands in bit 8
	a_store_flag: assert property (takeSeq |=>
		syndrome[ESC_POS_STORE] == $past(excStore))
		else $error("store flag not captured");

	// lock source lands with 11 folded to none
	a_lock_code: assert property (takeSeq |=>
		syndrome[ESC_POS_LOCK_HI:ESC_POS_LOCK_LO] ==
		(($past(excLockSrc) == ESC_LOCK_RSVD) ? ESC_LOCK_NONE : $past(excLockSrc)))
		else $error("lock source code wrong");

	// auxiliary processor cause
	a_aux_flag: assert property (takeSeq |=>
		syndrome[ESC_POS_AUX] == $past(excAux))
		else $error("aux flag not captured");

	// unimplemented operation, gated by program interrupt
	a_unimpl_flag: assert property (takeSeq |=>
		syndrome[ESC_POS_UNIMPL] == $past(excProgram && excUnimpl))
		else $error("unimplemented flag wrong");

	// byte ordering cause
	a_byte_order: assert property (takeSeq |=>
		syndrome[ESC_POS_BYTE] == $past(excByteOrder))
		else $error("byte order flag wrong");

	// imprecise needs a delayed fp-enabled interrupt with summary set
	a_imprecise_cause: assert property (takenSeq ##0 syndrome[ESC_POS_IMPREC] |->
		$past(excFpEnabled && excDelayed && fpEnabledSummary))
		else $error("imprecise set without cause");

	// imprecise flag follows the full imprecise condition
	a_imprecise_value: assert property (takeSeq |=>
		syndrome[ESC_POS_IMPREC] == $past(excFpEnabled && excDelayed && fpEnabledSummary
		&& (fpExcModeLow || fpExcModeHigh)))
		else $error("imprecise flag wrong");

	// fp qualifiers only beside a precise fp-enabled report
	a_qual_precise: assert property (takenSeq ##0
		(syndrome[ESC_POS_CRUPD] || syndrome[ESC_POS_CMP]) |->
		!syndrome[ESC_POS_IMPREC] && $past(excFpEnabled))
		else $error("fp qualifier outside precise fp case");

	// condition-update qualifier on a precise report
	a_crupd_flag: assert property (takeSeq ##1 !syndrome[ESC_POS_IMPREC]
		|-> syndrome[ESC_POS_CRUPD] == $past(excFpEnabled && excFpCrUpdate))
		else $error("condition update flag wrong");

	// compare qualifier on a precise report
	a_compare_flag: assert property (takeSeq ##1 !syndrome[ESC_POS_IMPREC]
		|-> syndrome[ESC_POS_CMP] == $past(excFpEnabled && excFpCompare))
		else $error("compare flag wrong");

	// field index loaded when condition-update is set
	a_field_index: assert property (takenSeq ##0 syndrome[ESC_POS_CRUPD] |->
		syndrome[ESC_POS_FIELD_HI:ESC_POS_FIELD_LO] == $past(excCrField))
		else $error("field index not loaded");

	// field index zero otherwise
	a_field_clear: assert property (takenSeq ##0 !syndrome[ESC_POS_CRUPD] |->
		syndrome[ESC_POS_FIELD_HI:ESC_POS_FIELD_LO] == ESC_FIELD_NONE)
		else $error("field index not cleared");

	// no capture and no write: register holds
	a_hold_idle: assert property (ce && !excTake && !sprWrite |=>
		$stable(syndrome))
		else $error("register changed without cause");

	// software write lands masked
	a_sw_write: assert property (writeSeq |=>
		syndrome == ($past(sprWriteData) & ESC_WRITE_MASK))
		else $error("software write not applied");

	// reserved bits read zero at all times
	a_reserved_zero: assert property (
		(syndrome & ~ESC_WRITE_MASK) == 32'h0000_0000)
		else $error("reserved bit nonzero");

	// clock enable low freezes the register
	a_freeze_ce: assert property (!ce |=> $stable(syndrome))
		else $error("state moved with clock enable low");

	// capture beats a software write in the same cycle
	a_capture_wins: assert property (bothSeq |=>
		syndrome[ESC_POS_LOW_HI:ESC_POS_LOW_LO] == $past(excLowSyndrome)
		&& syndrome[ESC_POS_STORE] == $past(excStore))
		else $error("write overrode a capture");

	// bits 0..7 follow the earlier syndrome logic on every capture
	a_low_bits: assert property (takeSeq |=>
		syndrome[ESC_POS_LOW_HI:ESC_POS_LOW_LO] == $past(excLowSyndrome))
		else $error("low syndrome bits not captured");

	// the reserved lock code never reaches the register on a capture
	a_lock_reserved: assert property (takeSeq |=>
		syndrome[ESC_POS_LOCK_HI:ESC_POS_LOCK_LO] != ESC_LOCK_RSVD)
		else $error("reserved lock code stored");

	// imprecise needs a nonzero fp exception mode
	a_imprecise_mode: assert property (takenSeq ##0 syndrome[ESC_POS_IMPREC] |->
		$past(fpExcModeLow || fpExcModeHigh))
		else $error("imprecise set with fp modes off");

	// a capture outside the fp-enabled case always reports precisely
	a_precise_nonfp: assert property (nonFpSeq |=>
		!syndrome[ESC_POS_IMPREC])
		else $error("imprecise set for non-fp interrupt");

	// fp qualifiers stay clear outside the fp-enabled case
	a_qual_nonfp: assert property (nonFpSeq |=>
		!syndrome[ESC_POS_CRUPD] && !syndrome[ESC_POS_CMP]
		&& syndrome[ESC_POS_FIELD_HI:ESC_POS_FIELD_LO] == ESC_FIELD_NONE)
		else $error("fp qualifier set outside fp case");

	// unimplemented flag only on a program interrupt
	a_unimpl_gate: assert property (takeSeq ##0 !excProgram |=>
		!syndrome[ESC_POS_UNIMPL])
		else $error("unimplemented flag outside program");

	// the register leaves reset at its reset value
	a_reset_value: assert property ($fell(rst) |-> syndrome == ESC_RESET)
		else $error("register not at reset value");

endmodule
`default_nettype wire

// *** test/esc_core_model.sv ***
`default_nettype none
// core exception logic and software move, seen from the syndrome block
module esc_core_model
	import esc_pkg::*;
(
	input  wire logic [24:0] cause,            // packed cause bundle
	input  wire logic        take,             // interrupt taken
	input  wire logic        wr,               // software move request
	input  wire logic [31:0] wrData,           // software move data
	output logic             excTake,
	output logic      [7:0]  excLowSyndrome,
	output logic             excStore,
	output logic      [1:0]  excLockSrc,
	output logic             excAux,
	output logic             excProgram,
	output logic             excUnimpl,
	output logic             excByteOrder,
	output logic             excFpEnabled,
	output logic             excDelayed,
	output logic             fpExcModeLow,
	output logic             fpExcModeHigh,
	output logic             fpEnabledSummary,
	output logic             excFpCrUpdate,
	output logic             excFpCompare,
	output logic      [2:0]  excCrField,
	output logic             sprWrite,
	output logic      [31:0] sprWriteData
);
	// cause lines follow the bundle while an interrupt is presented
	assign excTake = take;
	assign {excLowSyndrome, excStore, excLockSrc, excAux, excProgram, excUnimpl,
		excByteOrder, excFpEnabled, excDelayed, fpExcModeLow, fpExcModeHigh,
		fpEnabledSummary, excFpCrUpdate, excFpCompare, excCrField} = cause;
	// software move replaces the whole word
	assign sprWrite = wr;
	assign sprWriteData = wrData;
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`default_nettype none
module testbench
	import esc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;               // core clock
	logic        rst = 1'b1;               // async reset
	logic        ce = 1'b1;                // clock enable
	logic [24:0] cause = 25'h0;            // packed cause bundle
	logic        take = 1'b0;              // capture request
	logic        wr = 1'b0;                // software move request
	logic [31:0] wrData = 32'h0;           // software move data
	logic [31:0] syndrome;                 // register contents
	logic        excTake, excStore, excAux, excProgram, excUnimpl, excByteOrder;
	logic        excFpEnabled, excDelayed, fpExcModeLow, fpExcModeHigh;
	logic        fpEnabledSummary, excFpCrUpdate, excFpCompare, sprWrite;
	logic [7:0]  excLowSyndrome;
	logic [1:0]  excLockSrc;
	logic [2:0]  excCrField;
	logic [31:0] sprWriteData;
	int          n_fail = 0;               // mismatches
	int          n_tests = 0;              // comparisons
	// 100 MHz clock
	always #5 clk = ~clk;
	esc_core_model u_core (.cause, .take, .wr, .wrData, .excTake, .excLowSyndrome,
		.excStore, .excLockSrc, .excAux, .excProgram, .excUnimpl, .excByteOrder,
		.excFpEnabled, .excDelayed, .fpExcModeLow, .fpExcModeHigh, .fpEnabledSummary,
		.excFpCrUpdate, .excFpCompare, .excCrField, .sprWrite, .sprWriteData);
	esc_syndrome_capture u_dut (.clk, .rst, .ce, .excTake, .excLowSyndrome,
		.excStore, .excLockSrc, .excAux, .excProgram, .excUnimpl, .excByteOrder,
		.excFpEnabled, .excDelayed, .fpExcModeLow, .fpExcModeHigh, .fpEnabledSummary,
		.excFpCrUpdate, .excFpCompare, .excCrField, .sprWrite, .sprWriteData,
		.syndrome);
	// expected capture value, worked out from the bundle
	function automatic logic [31:0] expOf(input logic [24:0] c);
		logic        imp;
		logic        q;
		logic [31:0] e;
		imp = c[9] & c[8] & c[5] & (c[7] | c[6]);
		q = c[9] & ~imp;
		e = 32'h0;
		e[31:24] = c[24:17];
		e[23] = c[16];
		e[21:20] = (c[15:14] == 2'h3) ? 2'h0 : c[15:14];
		e[19] = c[13];
		e[18] = c[12] & c[11];
		e[17] = c[10];
		e[16] = imp;
		e[4] = q & c[4];
		e[3] = q & c[3];
		e[2:0] = (q & c[4]) ? c[2:0] : 3'h0;
		return e;
	endfunction
	// compare register against expectation
	task automatic check(input logic [31:0] e);
		n_tests++;
		if (syndrome !== e)
		begin
			n_fail++;
			$display("[ERR] %0t syndrome %h expected %h", $time, syndrome, e);
		end
	endtask
	// one capture, judged the cycle after
	task automatic capture(input logic [24:0] c, input logic w);
		@(negedge clk);
		cause = c;
		take = 1'b1;
		wr = w;
		@(negedge clk);
		take = 1'b0;
		wr = 1'b0;
		check(expOf(c));
	endtask
	// one software move, judged the cycle after
	task automatic swWrite(input logic [31:0] d);
		@(negedge clk);
		wrData = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		check(d & ESC_WRITE_MASK);
	endtask
	// plain causes over every lock code, one idle cycle apart
	task automatic tCauses();
		for (int i = 0; i < 4; i++)
		begin
			capture({8'hA5, i[0], i[1:0], ~i[0], 1'b1, i[1], i[0], 10'h0}, 1'b0);
		end
		capture(25'h0003800, 1'b0);
		capture(25'h0000800, 1'b0);
	endtask
	// floating-point precise and imprecise reporting
	task automatic tFp();
		for (int m = 0; m < 4; m++)
		begin
			capture({15'h0, 2'h3, m[1:0], 3'h7, 3'h5}, 1'b0);
		end
		capture({15'h0, 2'h2, 2'h3, 3'h7, 3'h6}, 1'b0);
		capture({15'h0, 2'h1, 2'h3, 3'h7, 3'h6}, 1'b0);
		for (int f = 0; f < 8; f++)
		begin
			capture({15'h0, 2'h2, 2'h0, 1'b1, f[0], f[1], f[2:0]}, 1'b0);
		end
	endtask
	// software moves, collision and clock enable
	task automatic tSoftware();
		swWrite(32'hFFFF_FFFF);
		capture(25'h0, 1'b0);
		swWrite(32'h1234_5678);
		wrData = 32'hFFFF_FFFF;
		capture(25'h1410000, 1'b1);
		@(negedge clk);
		ce = 1'b0;
		cause = 25'h1FFFFFF;
		take = 1'b1;
		wr = 1'b1;
		@(negedge clk);
		take = 1'b0;
		wr = 1'b0;
		ce = 1'b1;
		check(expOf(25'h1410000));
	endtask
	// reset in mid-run clears the register at once and again after release
	task automatic tReset();
		capture(25'h1FFFFFF, 1'b0);
		@(negedge clk);
		rst = 1'b1;
		#1;
		check(ESC_RESET);
		@(negedge clk);
		rst = 1'b0;
		check(ESC_RESET);
		capture(25'h0010000, 1'b0);
	endtask
	// verdict and end of run
	task automatic summarize();
		if (n_fail == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		check(ESC_RESET);
		tCauses();
		tFp();
		tSoftware();
		tReset();
		summarize();
	end
	// watchdog, far beyond the expected sixty cycles
	initial
	begin
		#20000;
		n_fail++;
		summarize();
	end
endmodule
`default_nettype wire
